// [src/clock_reset_mode_pkg.sv]
`default_nettype none

package clock_reset_mode_pkg;

  // ----------------
  // Timing counts
  // ----------------
  localparam int HOLD_OSC_CYCLES = 128;
  localparam int EDGES_PER_OSC = 2;
  localparam int SLEEP_DRAIN_CYCLES = 16;

  // ----------------
  // Register map: printed indices, byte address is four times the index
  // ----------------
  localparam logic [7:0] CTRL_INDEX = 8'h0f;
  localparam logic [7:0] STATUS_INDEX = 8'h0e;
  localparam logic [7:0] CTRL_ADDR = {CTRL_INDEX[5:0], 2'b00};
  localparam logic [7:0] STATUS_ADDR = {STATUS_INDEX[5:0], 2'b00};

  // ----------------
  // Field positions and reset values
  // ----------------
  localparam int REQ_LSB = 5;
  localparam int ABORT_BIT = 4;
  localparam int ONESHOT_BIT = 3;
  localparam int CLOCK_OUTPUT_ENABLE_BIT = 2;
  localparam int DIVSEL_LSB = 0;
  localparam int STAT_MODE_LSB = 5;
  localparam logic [7:0] CTRL_RESET = 8'h87;

  // ----------------
  // Operating mode codes, shared by request and status fields
  // ----------------
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h1;
  localparam logic [2:0] MODE_LOOPBACK = 3'h2;
  localparam logic [2:0] MODE_LISTEN = 3'h3;
  localparam logic [2:0] MODE_CONFIG = 3'h4;

  // ----------------
  // AXI response codes
  // ----------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic mode_is_valid(input logic [2:0] m);
    mode_is_valid = (m <= MODE_CONFIG);
  endfunction : mode_is_valid

  // Oscillator edges per output phase for a divider select
  function automatic logic [3:0] phase_edges(input logic [1:0] sel);
    phase_edges = 4'(4'h1 << sel);
  endfunction : phase_edges

endpackage : clock_reset_mode_pkg

`default_nettype wire

// [src/startup_hold_timer.sv]
`default_nettype none

module startup_hold_timer
  import clock_reset_mode_pkg::*;
#(
  parameter int HOLD_EDGES = HOLD_OSC_CYCLES * EDGES_PER_OSC
) (
  input wire logic clk, // system clock
  input wire logic srst, // any reset source, active high
  input wire logic restart, // wake from sleep, restart the hold
  input wire logic osc_tick, // one pulse per oscillator edge
  output logic holding // internal logic held in reset
);

  localparam int CNT_W = $clog2(HOLD_EDGES + 1);

  initial begin
    if (HOLD_EDGES < 1) begin
      $error("HOLD_EDGES must be at least 1");
    end
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic hold_reg;
  logic hold_next;

  // ----------------
  // Hold counter
  // ----------------
  always_comb begin
    cnt_next = cnt_reg;
    hold_next = hold_reg;
    if (restart) begin
      cnt_next = '0;
      hold_next = 1'b1;
    end else if (hold_reg && osc_tick) begin
      if (cnt_reg == CNT_W'(HOLD_EDGES - 1)) begin
        hold_next = 1'b0; // see R01
      end else begin
        cnt_next = cnt_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
      hold_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
    end
  end

  assign holding = hold_reg;

endmodule : startup_hold_timer

`default_nettype wire

// [src/clock_output_divider.sv]
`default_nettype none

module clock_output_divider
  import clock_reset_mode_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic srst, // any reset source, active high
  input wire logic osc_tick, // one pulse per oscillator edge
  input wire logic enable_req, // requested pin enable
  input wire logic [1:0] sel_req, // requested divider select
  input wire logic run_req, // keep toggling after this period
  output logic clk_out, // divided clock level
  output logic clk_oe, // pin driven when high
  output logic period_done // pulse at each falling edge
);

  logic out_reg, out_next;
  logic run_reg, run_next;
  logic en_reg, en_next;
  logic [1:0] sel_reg, sel_next;
  logic [3:0] cnt_reg, cnt_next;
  logic done_next;

  // ----------------
  // Settings are only taken while the output is low at a period boundary
  // ----------------
  always_comb begin
    out_next = out_reg;
    run_next = run_reg;
    en_next = en_reg;
    sel_next = sel_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (osc_tick) begin
      if (!run_reg) begin
        run_next = run_req; // see R06
        en_next = enable_req;
        sel_next = sel_req;
        cnt_next = 4'h0;
      end else if (cnt_reg == phase_edges(sel_reg) - 4'h1) begin
        cnt_next = 4'h0;
        out_next = ~out_reg; // see R03
        if (out_reg) begin
          done_next = 1'b1;
          run_next = run_req; // see R08
          en_next = enable_req;
          sel_next = sel_req;
        end
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_reg <= 1'b0;
      run_reg <= 1'b1;
      en_reg <= CTRL_RESET[CLOCK_OUTPUT_ENABLE_BIT]; // see R04
      sel_reg <= CTRL_RESET[DIVSEL_LSB+:2];
      cnt_reg <= 4'h0;
      period_done <= 1'b0;
    end else begin
      out_reg <= out_next;
      run_reg <= run_next;
      en_reg <= en_next;
      sel_reg <= sel_next;
      cnt_reg <= cnt_next;
      period_done <= done_next;
    end
  end

  assign clk_out = out_reg;
  assign clk_oe = en_reg; // see R07

endmodule : clock_output_divider

`default_nettype wire

// [src/clock_reset_mode_control.sv]
// What this block does
// R01 - Hold internal logic in reset 128 oscillator cycles after power-up or wake.
// R02 - Host should not use the serial port before the hold ends.
// R03 - Clock output is oscillator divided by 1, 2, 4 or 8.
// R04 - After reset the clock output is enabled and divides by eight.
// R05 - On sleep request emit sixteen more output cycles, then sleep.
// R06 - Clock output rests low while asleep.
// R07 - Enable bit low puts the clock output pin in high impedance.
// R08 - Enable, disable and divider changes never shorten a phase.
// R09 - Reset pin low and serial reset command act identically.
// R10 - System must apply one reset after power-up.
// R11 - Five modes chosen by the mode request field.
// R12 - Mode change waits until pending transmissions finish.
// R13 - Host reads mode status to confirm a requested mode.
// R14 - Status shows old mode until the change takes effect.
// R15 - Request codes: 0 normal, 1 sleep, 2 loopback, 3 listen, 4 config.
// R16 - Divider select 0..3 divides by 1, 2, 4, 8.
// R17 - Status reports the mode with the same codes as the request.
// R18 - Wake from sleep enters listen-only; normal only on host request.
`default_nettype none

module clock_reset_mode_control
  import clock_reset_mode_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int HOLD_CYCLES = HOLD_OSC_CYCLES,
  parameter int DRAIN_CYCLES = SLEEP_DRAIN_CYCLES
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic srst, // power-up reset, active high
  input wire logic reset_pin_n, // hardware reset pin, low resets
  input wire logic serial_reset_cmd, // serial reset command pulse
  input wire logic oscillator_input, // pulse per oscillator edge
  input wire logic tx_pending, // transmissions still pending
  input wire logic wake_event, // bus activity wake pulse
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic divided_clock_output, // clock output pin level
  output logic divided_clock_output_oe, // clock output pin drive
  output logic [2:0] mode_status, // current operating mode
  output logic startup_holding, // start-up hold active
  output logic abort_all_request, // abort pending transmissions
  output logic one_shot_mode // single transmit attempt
);

  initial begin
    if (ADDR_W < 8) begin
      $error("ADDR_W must be at least 8");
    end
    if (HOLD_CYCLES < 1 || DRAIN_CYCLES < 1 || DRAIN_CYCLES > 31) begin
      $error("HOLD_CYCLES or DRAIN_CYCLES out of range");
    end
  end

  typedef enum logic [1:0] {
    ST_RUN,
    ST_DRAIN,
    ST_SLEEP,
    ST_WAKE
  } sleep_state_e;

  // ----------------
  // Reset sources
  // ----------------
  logic int_reset;

  // Pin and serial reset share one path so their effect is the same
  assign int_reset = srst | ~reset_pin_n | serial_reset_cmd; // see R09

  // ----------------
  // Signals
  // ----------------
  logic holding;
  logic wake_start;
  logic wake_done;
  logic period_done;
  logic gen_run_req;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [2:0] mode_reg, mode_next;
  logic [4:0] drain_reg, drain_next;
  sleep_state_e state_reg, state_next;
  logic [2:0] req_mode;

  logic aw_hold_reg, aw_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic w_hold_reg, w_hold_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic aw_have, w_have, do_write, ctrl_write;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic wr_strb0;

  // ----------------
  // Start-up hold timer
  // ----------------
  startup_hold_timer #(
    .HOLD_EDGES(HOLD_CYCLES * EDGES_PER_OSC)
  ) u_hold (
    .clk(clk),
    .srst(int_reset),
    .restart(wake_start),
    .osc_tick(oscillator_input),
    .holding(holding)
  );

  // ----------------
  // Divided clock output
  // ----------------
  clock_output_divider u_clkdiv (
    .clk(clk),
    .srst(int_reset),
    .osc_tick(oscillator_input),
    .enable_req(ctrl_reg[CLOCK_OUTPUT_ENABLE_BIT]),
    .sel_req(ctrl_reg[DIVSEL_LSB+:2]), // see R16
    .run_req(gen_run_req),
    .clk_out(divided_clock_output),
    .clk_oe(divided_clock_output_oe),
    .period_done(period_done)
  );

  // Stop after the last drain period so the pin rests low in sleep
  always_comb begin
    gen_run_req = 1'b1;
    if (state_reg == ST_SLEEP || state_reg == ST_WAKE) begin
      gen_run_req = 1'b0; // see R06
    end else if (state_reg == ST_DRAIN &&
                 drain_reg == 5'(DRAIN_CYCLES - 1)) begin
      gen_run_req = 1'b0; // see R05
    end
  end

  // ----------------
  // Mode state machine
  // ----------------
  assign req_mode = ctrl_reg[REQ_LSB+:3];
  assign wake_start = (state_reg == ST_SLEEP) && wake_event;
  assign wake_done = (state_reg == ST_WAKE) && !holding;

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    drain_next = drain_reg;
    case (state_reg)
      ST_RUN: begin
        // Invalid codes and pending transmissions leave the mode alone
        if (!holding && mode_is_valid(req_mode) && // see R15
            req_mode != mode_reg && !tx_pending) begin // see R12
          if (req_mode == MODE_SLEEP) begin
            state_next = ST_DRAIN;
            drain_next = 5'h0;
          end else begin
            mode_next = req_mode; // see R11
          end
        end
      end
      ST_DRAIN: begin
        if (period_done) begin
          if (drain_reg == 5'(DRAIN_CYCLES - 1)) begin
            state_next = ST_SLEEP;
            mode_next = MODE_SLEEP; // see R14
          end else begin
            drain_next = drain_reg + 5'h1; // see R05
          end
        end
      end
      ST_SLEEP: begin
        if (wake_event) begin
          state_next = ST_WAKE; // see R01
        end
      end
      ST_WAKE: begin
        if (!holding) begin
          state_next = ST_RUN;
          mode_next = MODE_LISTEN; // see R18
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (int_reset) begin
      state_reg <= ST_RUN;
      mode_reg <= MODE_CONFIG;
      drain_reg <= 5'h0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      drain_reg <= drain_next;
    end
  end

  // ----------------
  // Control register
  // ----------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_write) begin
      ctrl_next = wr_data;
    end
    // Wake rewrites the request so sleep is not re-entered at once
    if (wake_done) begin
      ctrl_next[REQ_LSB+:3] = MODE_LISTEN; // see R18
    end
  end

  always_ff @(posedge clk) begin
    if (int_reset) begin
      ctrl_reg <= CTRL_RESET; // see R04
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------
  // AXI4-Lite slave
  // ----------------
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;

  assign aw_have = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
  assign w_have = w_hold_reg || (s_axi_wvalid && s_axi_wready);
  assign do_write = aw_have && w_have && !bvalid_reg;
  assign wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr[7:0];
  assign wr_data = w_hold_reg ? wdata_reg : s_axi_wdata[7:0];
  assign wr_strb0 = w_hold_reg ? wstrb0_reg : s_axi_wstrb[0];
  assign rd_addr = s_axi_araddr[7:0];
  // Writes during the start-up hold are acknowledged but dropped
  assign ctrl_write = do_write && wr_addr == CTRL_ADDR &&
                      wr_strb0 && !holding; // see R02

  always_comb begin
    aw_hold_next = aw_hold_reg;
    awaddr_next = awaddr_reg;
    w_hold_next = w_hold_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata[7:0];
      wstrb0_next = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wr_addr == CTRL_ADDR || wr_addr == STATUS_ADDR) ?
                   RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      if (rd_addr == CTRL_ADDR) begin
        rdata_next = {24'h0, ctrl_reg};
      end else if (rd_addr == STATUS_ADDR) begin
        rdata_next = 32'(mode_reg) << STAT_MODE_LSB; // see R17
      end else begin
        rdata_next = 32'h0;
        rresp_next = RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      w_hold_reg <= 1'b0;
      wdata_reg <= 8'h0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_hold_reg <= aw_hold_next;
      awaddr_reg <= awaddr_next;
      w_hold_reg <= w_hold_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ----------------
  // Outputs
  // ----------------
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign mode_status = mode_reg; // see R14
  assign startup_holding = holding;
  assign abort_all_request = ctrl_reg[ABORT_BIT];
  assign one_shot_mode = ctrl_reg[ONESHOT_BIT];

endmodule : clock_reset_mode_control

`default_nettype wire

// [tb/clock_reset_mode_properties.sv]
`default_nettype none

module clock_reset_mode_properties
  import clock_reset_mode_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_OSC_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic srst, // power-up reset
  input wire logic reset_pin_n, // reset pin
  input wire logic serial_reset_cmd, // serial reset
  input wire logic oscillator_input, // oscillator edge pulse
  input wire logic tx_pending, // pending transmissions
  input wire logic divided_clock_output, // clock output level
  input wire logic divided_clock_output_oe, // clock output drive
  input wire logic [2:0] mode_status, // current mode
  input wire logic startup_holding // start-up hold
);
  // ----------------------------------------------------------------
  // Phase and hold length counters
  // ----------------------------------------------------------------
  logic rst_any;
  logic out_reg, out_next;
  logic [15:0] ph_reg, ph_next, hold_reg, hold_next;
  assign rst_any = srst || !reset_pin_n || serial_reset_cmd;

  always_comb begin
    out_next = divided_clock_output;
    ph_next = ph_reg + 16'(oscillator_input);
    if (divided_clock_output != out_reg) begin
      ph_next = 16'(oscillator_input);
    end
    hold_next = 16'h0;
    if (startup_holding && !rst_any) begin
      hold_next = hold_reg + 16'(oscillator_input);
    end
  end

  always_ff @(posedge clk) begin
    out_reg <= out_next;
    ph_reg <= ph_next;
    hold_reg <= hold_next;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_RESET_DEFAULTS: assert property (
    !reset_pin_n || serial_reset_cmd |=> mode_status == MODE_CONFIG &&
    startup_holding && divided_clock_output_oe && !divided_clock_output)
    else $error("bad reset defaults");
  AST_HOLD_FROZEN: assert property (disable iff (rst_any)
    startup_holding ##1 startup_holding |-> $stable(mode_status))
    else $error("mode moved in hold");
  AST_HOLD_LEN: assert property (
    $fell(startup_holding) && !$past(rst_any) |->
    hold_reg >= 2 * HOLD_CYCLES - 1 && hold_reg <= 2 * HOLD_CYCLES + 1)
    else $error("hold length");
  AST_PHASE_POW2: assert property (
    $fell(divided_clock_output) && !$past(rst_any) |->
    ph_reg inside {16'h1, 16'h2, 16'h4, 16'h8})
    else $error("bad high phase");
  AST_OE_AT_LOW: assert property (
    $changed(divided_clock_output_oe) && !$past(rst_any) |->
    !divided_clock_output)
    else $error("drive changed high");
  AST_SLEEP_LOW: assert property (
    mode_status == MODE_SLEEP |-> !divided_clock_output)
    else $error("high in sleep");
  AST_SLEEP_AT_FALL: assert property (
    mode_status == MODE_SLEEP && $past(mode_status) != MODE_SLEEP |->
    $past(divided_clock_output) || $past(divided_clock_output, 2))
    else $error("sleep off a fall");
  AST_STATUS_CODE: assert property (
    mode_status <= MODE_CONFIG)
    else $error("bad mode code");
  AST_PENDING: assert property (
    $changed(mode_status) && !$past(rst_any) &&
    mode_status != MODE_SLEEP && $past(mode_status) != MODE_SLEEP |->
    !$past(tx_pending))
    else $error("change while pending");
  AST_WAKE_LISTEN: assert property (
    $fell(startup_holding) && $past(mode_status) == MODE_SLEEP |->
    ##[0:1] mode_status == MODE_LISTEN)
    else $error("wake not listen");

  cover property ($rose(mode_status == MODE_SLEEP));
  cover property ($fell(divided_clock_output_oe));
  cover property ($fell(startup_holding) && $past(mode_status) == MODE_SLEEP);
endmodule : clock_reset_mode_properties

bind clock_reset_mode_control clock_reset_mode_properties #(
  .HOLD_CYCLES(HOLD_CYCLES)
) props_u (.clk(clk), .srst(srst), .reset_pin_n(reset_pin_n),
  .serial_reset_cmd(serial_reset_cmd), .oscillator_input(oscillator_input),
  .tx_pending(tx_pending), .divided_clock_output(divided_clock_output),
  .divided_clock_output_oe(divided_clock_output_oe),
  .mode_status(mode_status), .startup_holding(startup_holding));

`default_nettype wire

// [tb/host_clock_partner.sv]
`default_nettype none

module host_clock_partner (
  input wire logic clk, // system clock
  input wire logic clr, // clear the fall count
  input wire logic drv, // clock output level
  input wire logic oe, // clock output drive
  output logic osc, // oscillator edge pulse
  output logic pin, // level seen on the pin
  output int falls // falls seen while driven
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  initial begin
    osc = 1'b0;
    last = 1'b0;
    falls = 0;
  end
  // Undriven pin has no pull: show the inverse of the last level
  assign pin = oe ? drv : ~last;
  always @(posedge clk) begin
    osc <= !osc;
    if (oe) begin
      last <= drv;
    end
    if (clr) begin
      falls <= 0;
    end else if (oe && last && !drv) begin
      falls <= falls + 1;
    end
  end
endmodule : host_clock_partner

`default_nettype wire

// [tb/clock_reset_mode_control_bench.sv]
`default_nettype none

module clock_reset_mode_control_bench
  import clock_reset_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, reset_pin_n, serial_reset_cmd, oscillator_input;
  logic tx_pending, wake_event, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, divided_clock_output;
  logic divided_clock_output_oe, startup_holding, abort_all_request;
  logic one_shot_mode, clr, pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] mode_status, prev, expm;
  logic [2:0] req_tab [5] = '{MODE_NORMAL, MODE_LOOPBACK, MODE_LISTEN,
    MODE_CONFIG, 3'h5};
  int err_total = 0;
  int n_tests = 0;
  int falls;

  clock_reset_mode_control #(.HOLD_CYCLES(4)) dut_u (.clk, .srst,
    .reset_pin_n, .serial_reset_cmd, .oscillator_input, .tx_pending,
    .wake_event, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .divided_clock_output, .divided_clock_output_oe, .mode_status,
    .startup_holding, .abort_all_request, .one_shot_mode);

  host_clock_partner host_u (.clk(clk), .clr(clr), .drv(divided_clock_output),
    .oe(divided_clock_output_oe), .osc(oscillator_input), .pin(pin),
    .falls(falls));

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : chk

  task automatic hold_end();
    for (int i = 0; i < 500 && startup_holding !== 1'b0; i++) @(posedge clk);
    chk("hold end", 32'h0, startup_holding);
  endtask : hold_end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    {srst, reset_pin_n, serial_reset_cmd, tx_pending, wake_event} = 5'h18;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h1;
    {s_axi_arvalid, s_axi_rready, clr} = 3'h2;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(STATUS_ADDR);
    chk("status", {24'h0, MODE_CONFIG, 5'h0}, d);
    rd(CTRL_ADDR);
    chk("ctrl", 32'h87, d);
    chk("oe", 1'b1, divided_clock_output_oe);
    hold_end();
    for (int s = 0; s < 4; s++) begin
      wr(CTRL_ADDR, {24'h0, MODE_CONFIG, 3'b001, 2'(s)});
      rd(CTRL_ADDR);
      chk("divider", {24'h0, MODE_CONFIG, 3'b001, 2'(s)}, d);
      repeat (80) @(posedge clk);
    end
    wr(CTRL_ADDR, {24'h0, MODE_CONFIG, 3'b000, 2'b11});
    repeat (40) @(posedge clk);
    chk("oe off", 1'b0, divided_clock_output_oe);
    wr(CTRL_ADDR, {24'h0, MODE_CONFIG, 3'b001, 2'b11});
    $display("clock output test done");
    prev = MODE_CONFIG;
    for (int k = 0; k < 5; k++) begin
      expm = (req_tab[k] <= MODE_CONFIG) ? req_tab[k] : prev;
      tx_pending <= 1'b1;
      wr(CTRL_ADDR, {24'h0, req_tab[k], 3'b001, 2'b11});
      repeat (20) @(posedge clk);
      chk("mode held", prev, mode_status);
      tx_pending <= 1'b0;
      repeat (4) @(posedge clk);
      rd(STATUS_ADDR);
      chk("mode", {24'h0, expm, 5'h0}, d);
      prev = expm;
    end
    $display("mode test done");
    while (divided_clock_output !== 1'b0) @(posedge clk);
    while (divided_clock_output !== 1'b1) @(posedge clk);
    clr <= 1'b1;
    wr(CTRL_ADDR, {24'h0, MODE_SLEEP, 3'b001, 2'b11});
    clr <= 1'b0;
    for (int i = 0; i < 2000 && mode_status !== MODE_SLEEP; i++) begin
      @(posedge clk);
    end
    chk("drain falls", 16, falls);
    repeat (40) @(posedge clk);
    chk("sleep level", 1'b0, divided_clock_output);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    @(posedge clk);
    hold_end();
    repeat (2) @(posedge clk);
    chk("wake mode", MODE_LISTEN, mode_status);
    rd(CTRL_ADDR);
    chk("wake request", MODE_LISTEN, d[7:5]);
    $display("sleep test done");
    for (int k = 0; k < 2; k++) begin
      wr(CTRL_ADDR, {24'h0, MODE_NORMAL, 3'b110, 2'b00});
      repeat (4) @(posedge clk);
      chk("one shot", 2'b11, {abort_all_request, one_shot_mode});
      if (k == 0) reset_pin_n <= 1'b0;
      else serial_reset_cmd <= 1'b1;
      @(posedge clk);
      {reset_pin_n, serial_reset_cmd} <= 2'b10;
      @(posedge clk);
      rd(CTRL_ADDR);
      chk("reset ctrl", 32'h87, d);
      chk("reset mode", MODE_CONFIG, mode_status);
      hold_end();
    end
    wr(8'h00, 32'h0);
    chk("unmapped write", RESP_SLVERR, r);
    rd(8'h00);
    chk("unmapped read", {RESP_SLVERR, 32'h0}, {r, d});
    $display("reset and bus test done");
    print_verdict();
  end
endmodule : clock_reset_mode_control_bench

`default_nettype wire
